/* File: adcs_pkg.sv */
// Constants shared by the conversion sequencer and its helpers.
// Assumes a 100 MHz clock with one converter cycle per clock.
package adcs_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Conversion length in converter cycles, one converter cycle per clock
  localparam int unsigned CONV_CYCLES = 57;
  localparam int unsigned SWEEP_CYCLES = 456;
  localparam int unsigned NUM_BITS = 8;
  localparam int unsigned STEP_CYCLES = (CONV_CYCLES - 1) / NUM_BITS;
  localparam logic [5:0] CNT_LAST = 6'(CONV_CYCLES - 1);
  localparam logic [5:0] CNT_STEP = 6'(STEP_CYCLES);
  localparam logic [5:0] CNT_STEP_LAST = 6'(STEP_CYCLES - 1);
  localparam logic [5:0] CNT_ZERO = 6'h00;

  localparam int unsigned DW = 8;
  localparam int unsigned AW = 4;
  localparam int unsigned NUM_CH = 8;
  localparam logic [2:0] CH_FIRST = 3'h0;
  localparam logic [2:0] CH_LAST = 3'h7;
  localparam logic [2:0] BIT_MSB = 3'h7;
  localparam logic [2:0] BIT_LSB = 3'h0;
  localparam logic [7:0] SAR_MSB_ONLY = 8'h80;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h1;
  localparam logic [3:0] OFS_RES0 = 4'h8;

  // Control and status field positions
  localparam int unsigned CTRL_CH_LSB = 0;
  localparam int unsigned CTRL_MODE_LSB = 3;
  localparam int unsigned CTRL_TRIG = 5;
  localparam int unsigned CTRL_START = 6;
  localparam int unsigned STAT_IRQ = 0;
  localparam int unsigned STAT_BUSY = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  typedef enum logic [1:0] {
    ADCS_ONE_SHOT = 2'b00,
    ADCS_REPEAT = 2'b01,
    ADCS_SWEEP = 2'b10,
    ADCS_REP_SWEEP = 2'b11
  } adcs_mode_e;
endpackage

/* File: adcs_sar_if.sv */
// Link between the sequencer and the successive approximation core.
// Assumes both ends run on the one block clock.
`timescale 1ns/1ps
interface adcs_sar_if;
  logic start;
  logic cmp_above;
  logic done;
  logic [7:0] result;
  logic [7:0] code;
  logic busy;
  modport seq (output start, output cmp_above, input done, input result, input code,
    input busy);
  modport core (input start, input cmp_above, output done, output result, output code,
    output busy);
endinterface

/* File: adcs_trig_edge.sv */
// Falling edge detector for the external trigger pin.
// Assumes the pin is already synchronous to the clock.
`timescale 1ns/1ps
module adcs_trig_edge (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_pin_n,
  output logic o_fall
);
  logic prev_q;

  // Idle high, so a pin held low at reset reads as one edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= i_pin_n;
    end
  end

  assign o_fall = prev_q & ~i_pin_n;
endmodule

/* File: adcs_sar_core.sv */
// Successive approximation core: eight comparisons over one conversion.
// Assumes the comparator output settles within one step.
`timescale 1ns/1ps
module adcs_sar_core (
  input wire logic i_clk,
  input wire logic i_rst_b,
  adcs_sar_if.core sar
);
  logic [5:0] cnt_q;
  logic [5:0] step_q;
  logic [2:0] bit_q;
  logic [7:0] code_q;
  logic busy_q;
  logic decide;
  logic last;

  localparam logic [5:0] CNT_STEP_LAST_W = adcs_pkg::CNT_STEP_LAST;

  assign decide = busy_q && (step_q == CNT_STEP_LAST_W);
  // Last cycle: bit 0 is decided, so the code already is the result
  assign last = busy_q && (cnt_q == adcs_pkg::CNT_LAST);

  // A start mid conversion begins again from the first step
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= adcs_pkg::CNT_ZERO;
      step_q <= adcs_pkg::CNT_ZERO;
      busy_q <= 1'b0;
    end else if (sar.start) begin
      cnt_q <= adcs_pkg::CNT_ZERO;
      step_q <= adcs_pkg::CNT_ZERO;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 6'h01;
      step_q <= decide ? adcs_pkg::CNT_ZERO : step_q + 6'h01;
      busy_q <= (cnt_q != adcs_pkg::CNT_LAST);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      code_q <= adcs_pkg::BYTE_ZERO;
      bit_q <= adcs_pkg::BIT_MSB;
    end else if (sar.start) begin
      code_q <= adcs_pkg::SAR_MSB_ONLY;
      bit_q <= adcs_pkg::BIT_MSB;
    end else if (decide && (cnt_q < adcs_pkg::CNT_LAST)) begin
      // Bit kept only while the input stands above the reference
      code_q[bit_q] <= sar.cmp_above;
      if (bit_q != adcs_pkg::BIT_LSB) begin
        code_q[bit_q - 3'h1] <= 1'b1;
        bit_q <= bit_q - 3'h1;
      end
    end
  end

  // Done stands in the last cycle, so a follow-on conversion starts with no gap
  assign sar.done = last;
  assign sar.result = code_q;
  assign sar.code = code_q;
  assign sar.busy = busy_q;
endmodule

/* File: adcs_seq.sv */
// Conversion sequencer: control, result registers and mode sequencing.
// Assumes register strobes are one cycle and synchronous to I_CLK.
//
// Notes on behaviour
// - Mode field 00 one-shot, 01 repeat, 10 single sweep, 11 repeat sweep.
// - Trigger select bit chooses software start flag or external trigger pin.
// - Software trigger: conversion begins when software writes one to start flag.
// - External trigger: falling pin edge starts conversion, only while start flag is one.
// - One-shot conversion ends after 57 cycles, stores result, sets interrupt request.
// - One-shot with software trigger clears start flag and halts after completion.
// - One-shot with external trigger keeps start flag set for later edges.
// - External trigger edge accepted while conversion is still in progress.
// - Such an edge aborts the sequence and restarts from its first step.
// - Repeat mode converts continuously while start is one; no interrupt, no clear.
// - Repeat mode updates the channel result after every conversion.
// - Single sweep converts channels zero to seven in order, storing each.
// - Single sweep raises interrupt after channel seven; software trigger then stops.
// - Single sweep external trigger keeps start flag; next edge restarts at zero.
// - Repeat sweep wraps from seven to zero until start cleared; no interrupt.
// - Sweeps with external trigger still convert channel seven, the trigger pin.
// - A full sweep completes channel seven 456 cycles after its start.
// - Result register written only after the bit 0 comparison completes.
`timescale 1ns/1ps
module adcs_seq (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_EXT_CONV_TRIGGER_N,
  input wire logic I_CMP_ABOVE,
  input wire logic I_IRQ_ACK,
  output logic [7:0] O_RDATA,
  output logic [2:0] O_CHANNEL,
  output logic [7:0] O_DAC_CODE,
  output logic O_BUSY,
  output logic O_IRQ_REQ
);
  typedef enum logic {
    ADCS_IDLE,
    ADCS_CONV
  } adcs_state_e;

  adcs_sar_if sar ();

  adcs_state_e state_q;
  logic [2:0] chan_sel_q;
  adcs_pkg::adcs_mode_e mode_q;
  logic trig_ext_q;
  logic start_q;
  logic irq_q;
  logic [2:0] chan_q;
  logic [7:0] rdata_q;
  logic [7:0] dac_q;
  logic busy_q;
  logic [7:0] result_q [adcs_pkg::NUM_CH];

  logic ext_fall;
  logic wr_ctrl;
  logic wr_stat;
  logic sw_go;
  logic ext_go;
  logic go;
  logic is_sweep;
  logic last_ch;
  logic seq_end;
  logic hw_clear;
  logic hw_irq;
  logic continue_conv;
  logic stop_req;
  logic [2:0] first_ch;
  logic [1:0] wr_mode;
  logic wr_sweep;

  adcs_trig_edge u_edge (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .i_pin_n(I_EXT_CONV_TRIGGER_N),
    .o_fall(ext_fall)
  );

  adcs_sar_core u_core (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .sar(sar.core)
  );

  assign wr_ctrl = I_WR && (I_ADDR == adcs_pkg::OFS_CTRL);
  assign wr_stat = I_WR && (I_ADDR == adcs_pkg::OFS_STAT);

  // Mode decoded from the stored field
  assign is_sweep = (mode_q == adcs_pkg::ADCS_SWEEP) ||
    (mode_q == adcs_pkg::ADCS_REP_SWEEP);
  // A starting write takes effect at once, so its own mode and channel count
  assign wr_mode = I_WDATA[adcs_pkg::CTRL_MODE_LSB +: 2];
  assign wr_sweep = (wr_mode == adcs_pkg::ADCS_SWEEP) || (wr_mode == adcs_pkg::ADCS_REP_SWEEP);
  assign first_ch = !sw_go ? (is_sweep ? adcs_pkg::CH_FIRST : chan_sel_q) :
    wr_sweep ? adcs_pkg::CH_FIRST : I_WDATA[adcs_pkg::CTRL_CH_LSB +: 3];
  assign last_ch = (chan_q == adcs_pkg::CH_LAST);

  // Software trigger: a write of one to the start flag in internal mode
  assign sw_go = wr_ctrl && I_WDATA[adcs_pkg::CTRL_START] &&
    !I_WDATA[adcs_pkg::CTRL_TRIG];
  // External trigger counts only while the start flag holds one
  assign ext_go = trig_ext_q && start_q && ext_fall && !wr_ctrl;
  assign go = sw_go || ext_go;

  // Writing zero to the start flag halts the converter
  assign stop_req = wr_ctrl && !I_WDATA[adcs_pkg::CTRL_START];

  // End of the sequence on the completion of a conversion
  always_comb begin
    seq_end = 1'b0;
    continue_conv = 1'b0;
    hw_irq = 1'b0;
    case (mode_q)
      adcs_pkg::ADCS_ONE_SHOT: begin
        seq_end = 1'b1;
        hw_irq = 1'b1;
      end
      adcs_pkg::ADCS_REPEAT: begin
        continue_conv = start_q;
      end
      adcs_pkg::ADCS_SWEEP: begin
        seq_end = last_ch;
        continue_conv = !last_ch;
        hw_irq = last_ch;
      end
      adcs_pkg::ADCS_REP_SWEEP: begin
        continue_conv = start_q;
      end
      default: begin
        seq_end = 1'b1;
      end
    endcase
  end

  // Only the internal trigger gives up its start flag at the end
  assign hw_clear = (state_q == ADCS_CONV) && sar.done && seq_end &&
    !trig_ext_q;

  // Control register
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      chan_sel_q <= adcs_pkg::CTRL_RESET[2:0];
      mode_q <= adcs_pkg::ADCS_ONE_SHOT;
      trig_ext_q <= 1'b0;
    end else if (wr_ctrl) begin
      chan_sel_q <= I_WDATA[adcs_pkg::CTRL_CH_LSB +: 3];
      mode_q <= adcs_pkg::adcs_mode_e'(I_WDATA[adcs_pkg::CTRL_MODE_LSB +: 2]);
      trig_ext_q <= I_WDATA[adcs_pkg::CTRL_TRIG];
    end
  end

  // Start flag; a software write of one wins over the hardware clear
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      start_q <= 1'b0;
    end else if (wr_ctrl) begin
      start_q <= I_WDATA[adcs_pkg::CTRL_START];
    end else if (hw_clear) begin
      start_q <= 1'b0;
    end
  end

  // Interrupt request is sticky; a new event beats a clear
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      irq_q <= 1'b0;
    end else if ((state_q == ADCS_CONV) && sar.done && hw_irq) begin
      irq_q <= 1'b1;
    end else if (I_IRQ_ACK || (wr_stat && !I_WDATA[adcs_pkg::STAT_IRQ])) begin
      irq_q <= 1'b0;
    end
  end

  // Sequencing state and channel pointer
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_q <= ADCS_IDLE;
      chan_q <= adcs_pkg::CH_FIRST;
    end else if (go) begin
      // A trigger in mid sequence aborts and starts over
      state_q <= ADCS_CONV;
      chan_q <= first_ch;
    end else if (stop_req) begin
      state_q <= ADCS_IDLE;
    end else if ((state_q == ADCS_CONV) && sar.done) begin
      if (continue_conv) begin
        // Sweep steps on; channel seven wraps back to zero
        chan_q <= is_sweep ? chan_q + 3'h1 : chan_q;
      end else begin
        state_q <= ADCS_IDLE;
      end
    end
  end

  // The core restarts on any trigger or when the sequence carries on
  assign sar.start = go || ((state_q == ADCS_CONV) && sar.done && continue_conv &&
    !stop_req);
  assign sar.cmp_above = I_CMP_ABOVE;

  // Result registers, one per channel; channel seven is the trigger pin in
  // external sweeps and is converted like any other
  genvar gi;
  generate
    for (gi = 0; gi < adcs_pkg::NUM_CH; gi = gi + 1) begin : g_res
      always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          result_q[gi] <= adcs_pkg::BYTE_ZERO;
        end else if ((state_q == ADCS_CONV) && sar.done && (chan_q == 3'(gi))) begin
          result_q[gi] <= sar.result;
        end
      end
    end
  endgenerate

  // Read port; data stands one cycle after the strobe
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rdata_q <= adcs_pkg::BYTE_ZERO;
    end else if (I_RD) begin
      if (I_ADDR == adcs_pkg::OFS_CTRL) begin
        rdata_q <= {1'b0, start_q, trig_ext_q, mode_q, chan_sel_q};
      end else if (I_ADDR == adcs_pkg::OFS_STAT) begin
        rdata_q <= {6'h00, busy_q, irq_q};
      end else if (I_ADDR >= adcs_pkg::OFS_RES0) begin
        // Channel in progress still shows its previous result
        rdata_q <= result_q[I_ADDR[2:0]];
      end else begin
        rdata_q <= adcs_pkg::BYTE_ZERO;
      end
    end else begin
      rdata_q <= adcs_pkg::BYTE_ZERO;
    end
  end

  // Analog side outputs, registered once more to come straight from flops
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      dac_q <= adcs_pkg::BYTE_ZERO;
      busy_q <= 1'b0;
    end else begin
      dac_q <= sar.code;
      busy_q <= (state_q == ADCS_CONV);
    end
  end

  assign O_RDATA = rdata_q;
  assign O_CHANNEL = chan_q;
  assign O_DAC_CODE = dac_q;
  assign O_BUSY = busy_q;
  assign O_IRQ_REQ = irq_q;
endmodule

/* File: adcs_afe_model.sv */
// Comparator model for the analog inputs beside the sequencer.
// Assumes one static level per channel, set by the bench.
`timescale 1ns/1ps
module adcs_afe_model (
  input wire logic [2:0] i_channel,
  input wire logic [7:0] i_code,
  input wire logic [63:0] i_levels,
  output logic o_cmp_above
);
  // Reference sits half a step below the code, so equal reads as above
  assign o_cmp_above = i_levels[i_channel*8 +: 8] >= i_code;
endmodule

/* File: adcs_seq_props.sv */
// Checker on the sequencer top ports.
// Assumes a bind to adcs_seq; shadows control writes.
`timescale 1ns/1ps
module adcs_seq_props (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_EXT_CONV_TRIGGER_N,
  input wire logic I_IRQ_ACK,
  input wire logic [2:0] O_CHANNEL,
  input wire logic O_BUSY,
  input wire logic O_IRQ_REQ
);
  logic [1:0] mode_q;
  logic trig_q;
  logic start_q;
  logic pin_q;
  logic [9:0] cnt_q;
  logic wr_c;
  logic sw_go;
  logic ext_go;
  logic clr;
  assign wr_c = I_WR && I_ADDR == adcs_pkg::OFS_CTRL;
  assign sw_go = wr_c && I_WDATA[6] && !I_WDATA[5];
  assign ext_go = pin_q && !I_EXT_CONV_TRIGGER_N && trig_q && start_q && !wr_c;
  assign clr = I_IRQ_ACK || (I_WR && I_ADDR == adcs_pkg::OFS_STAT && !I_WDATA[0]);
  // Shadow ignores hardware clears; those only occur with software trigger
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      mode_q <= 2'h0;
      trig_q <= 1'b0;
      start_q <= 1'b0;
    end else if (wr_c) begin
      mode_q <= I_WDATA[4:3];
      trig_q <= I_WDATA[5];
      start_q <= I_WDATA[6];
    end
  end
  // Cycles since the last accepted trigger, saturating
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pin_q <= 1'b1;
      cnt_q <= 10'h3ff;
    end else begin
      pin_q <= I_EXT_CONV_TRIGGER_N;
      if (sw_go || ext_go) begin
        cnt_q <= 10'h000;
      end else if (cnt_q != 10'h3ff) begin
        cnt_q <= cnt_q + 10'h001;
      end
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  sequence s_begin;
    ##2 O_BUSY;
  endsequence
  property p_sw; sw_go |-> s_begin; endproperty
  a_sw: assert property (p_sw) else $error("no busy after start write");
  property p_ext; ext_go |-> s_begin; endproperty
  a_ext: assert property (p_ext) else $error("no busy after trigger edge");
  property p_one;
    $rose(O_IRQ_REQ) && mode_q == 2'h0 |-> cnt_q == 10'(adcs_pkg::CONV_CYCLES);
  endproperty
  a_one: assert property (p_one) else $error("one-shot length wrong");
  property p_swp;
    $rose(O_IRQ_REQ) && mode_q == 2'h2 |-> cnt_q == 10'(adcs_pkg::SWEEP_CYCLES);
  endproperty
  a_swp: assert property (p_swp) else $error("sweep length wrong");
  property p_rep; mode_q[0] |-> !$rose(O_IRQ_REQ); endproperty
  a_rep: assert property (p_rep) else $error("repeat raised interrupt");
  property p_hold; O_IRQ_REQ && !clr |=> O_IRQ_REQ; endproperty
  a_hold: assert property (p_hold) else $error("interrupt dropped");
  property p_chan;
    mode_q[1] && $changed(O_CHANNEL) |-> O_CHANNEL == $past(O_CHANNEL) + 3'h1 ||
      O_CHANNEL == 3'h0;
  endproperty
  a_chan: assert property (p_chan) else $error("sweep order wrong");
  property p_stop; $rose(O_IRQ_REQ) && !trig_q && !mode_q[0] |=> !O_BUSY; endproperty
  a_stop: assert property (p_stop) else $error("no halt after completion");
endmodule

/* File: tb.sv */
// Self-checking bench for the sequencer with a comparator model.
// Assumes one 100 MHz clock; the checker is bound here.
`timescale 1ns/1ps
bind adcs_seq adcs_seq_props u_props (.*);
module tb;
  logic I_CLK, I_RST_B, I_WR, I_RD, I_EXT_CONV_TRIGGER_N, I_CMP_ABOVE, I_IRQ_ACK;
  logic [3:0] I_ADDR;
  logic [7:0] I_WDATA, O_RDATA, O_DAC_CODE;
  logic [2:0] O_CHANNEL;
  logic O_BUSY, O_IRQ_REQ;
  logic [63:0] levels;
  int fail_count, checks, cyc, seed, ch;
  int lv[8];
  int res[8];
  adcs_seq dut_u (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .I_EXT_CONV_TRIGGER_N(I_EXT_CONV_TRIGGER_N),
    .I_CMP_ABOVE(I_CMP_ABOVE), .I_IRQ_ACK(I_IRQ_ACK), .O_RDATA(O_RDATA),
    .O_CHANNEL(O_CHANNEL), .O_DAC_CODE(O_DAC_CODE), .O_BUSY(O_BUSY), .O_IRQ_REQ(O_IRQ_REQ));
  adcs_afe_model afe_u (.i_channel(O_CHANNEL), .i_code(O_DAC_CODE), .i_levels(levels),
    .o_cmp_above(I_CMP_ABOVE));
  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      fail_count++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1;
    chk(O_RDATA === e, "read data");
  endtask
  task automatic shuffle(input bit pin7);
    for (int i = 0; i < 8; i++) begin
      // Channel seven is the trigger pin, idle high, in external sweeps
      lv[i] = (pin7 && i == 7) ? 255 : $random(seed) & 255;
      levels[i*8 +: 8] <= 8'(lv[i]);
    end
  endtask
  task automatic fall();
    @(posedge I_CLK);
    I_EXT_CONV_TRIGGER_N <= 1'b0;
    repeat (4) @(posedge I_CLK);
    I_EXT_CONV_TRIGGER_N <= 1'b1;
    repeat (16) @(posedge I_CLK);
  endtask
  // Model: stored results follow levels of each converted channel
  task automatic upd_check(input logic [7:0] c);
    for (int i = 0; i < 8; i++) if (c[4] || i == c[2:0]) res[i] = lv[i];
    for (int i = 0; i < 8; i++) rd(adcs_pkg::OFS_RES0 + 4'(i), 8'(res[i]));
  endtask
  task automatic conv(input logic [7:0] c);
    shuffle(c[5] && c[4]);
    wr(adcs_pkg::OFS_CTRL, c);
    rd(adcs_pkg::OFS_RES0 + {1'b0, c[4] ? 3'h0 : c[2:0]}, 8'(res[c[4] ? 0 : c[2:0]]));
    if (!c[5]) chk(O_CHANNEL === (c[4] ? 3'h0 : c[2:0]) && O_DAC_CODE === 8'h80, "go");
    // Second edge lands mid-conversion to force a restart
    if (c[5]) repeat (2) fall();
    for (int i = 0; i < 700 && O_IRQ_REQ !== 1'b1; i++) begin
      @(posedge I_CLK);
      #1;
    end
    chk(O_IRQ_REQ === 1'b1, "no interrupt");
    upd_check(c);
    rd(adcs_pkg::OFS_CTRL, c[5] ? c : c & 8'hbf);
    rd(adcs_pkg::OFS_STAT, 8'h01);
    if (c[5]) begin
      @(posedge I_CLK);
      I_IRQ_ACK <= 1'b1;
      @(posedge I_CLK);
      I_IRQ_ACK <= 1'b0;
    end else wr(adcs_pkg::OFS_STAT, 8'h00);
    @(posedge I_CLK);
    #1;
    chk(O_IRQ_REQ === 1'b0, "interrupt stuck");
  endtask
  task automatic rep(input logic [7:0] c);
    wr(adcs_pkg::OFS_CTRL, c);
    repeat (2) begin
      shuffle(1'b0);
      repeat (1000) @(posedge I_CLK);
      #1;
      upd_check(c);
    end
    chk(O_IRQ_REQ === 1'b0, "repeat interrupt");
    rd(adcs_pkg::OFS_CTRL, c);
    wr(adcs_pkg::OFS_CTRL, 8'h00);
  endtask
  initial begin
    I_RST_B = 1'b0;
    I_WR = 1'b0;
    I_RD = 1'b0;
    I_IRQ_ACK = 1'b0;
    I_EXT_CONV_TRIGGER_N = 1'b1;
    I_ADDR = 4'h0;
    I_WDATA = 8'h00;
    seed = 32'hc340f065;
    shuffle(1'b0);
    repeat (2) @(posedge I_CLK);
    I_RST_B <= 1'b1;
    rd(adcs_pkg::OFS_CTRL, adcs_pkg::CTRL_RESET);
    rd(adcs_pkg::OFS_STAT, 8'h00);
    wr(4'h2, 8'hff);
    rd(4'h2, 8'h00);
    wr(adcs_pkg::OFS_CTRL, 8'h20);
    fall();
    chk(O_BUSY === 1'b0, "edge without start");
    wr(adcs_pkg::OFS_CTRL, 8'h60);
    repeat (4) @(posedge I_CLK);
    #1;
    chk(O_BUSY === 1'b0, "write started external mode");
    for (int k = 0; k < 2; k++) begin
      ch = ($random(seed) & 7) % 7;
      conv(8'h40 | 8'(ch));
      conv(8'h60 | 8'(ch));
    end
    conv(8'h50);
    conv(8'h70);
    rep(8'h48 | 8'(ch));
    rep(8'h58);
    tally_and_finish();
  end
endmodule
